// ---- rtl/cir_gate.sv ----
// request gate: pending and mask and global enable make the exception
// assumes all inputs synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
module cir_gate (
    input  wire logic aclk,
    input  wire logic aresetn,
    cir_if.gate       g
);
    import cir_pkg::*;
    logic take_next;
    assign take_next = g.enable && |(g.pending & g.mask);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            g.take <= 1'b0;
        end else begin
            g.take <= take_next;
        end
    end
    off_when_disabled_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !$past(g.enable) |-> !g.take) else $error("take while disabled");
endmodule
`default_nettype wire

// ---- rtl/cir_if.sv ----
// carrier between the interrupt core and its request gate
// assumes both ends share aclk
`timescale 1ns/10ps
`default_nettype none
interface cir_if;
    logic [7:0] pending;
    logic [7:0] mask;
    logic       enable;
    logic       take;
    modport core (output pending, output mask, output enable, input take);
    modport gate (input pending, input mask, input enable, output take);
endinterface
`default_nettype wire

// ---- rtl/cir_pkg.sv ----
// package for the processor interrupt request logic
// assumes a single 10 MHz clock and an AXI4-Lite register path
package cir_pkg;
    localparam int          HW_IRQS      = 6;
    localparam int          SW_IRQS      = 2;
    localparam int          IRQ_BITS     = 8;
    localparam int          SW_LSB       = 8;
    localparam int          HW_LSB       = 10;
    localparam int          HW_MSB       = 15;
    localparam int          MASK_LSB     = 8;
    localparam int          IE_BIT       = 0;
    localparam int          EXL_BIT      = 1;
    localparam int          ERL_BIT      = 2;
    localparam int          CODE_LSB     = 2;
    localparam int          FPU_HW_IDX   = 3;
    localparam int          TIMER_HW_IDX = 5;
    localparam logic [4:0]  CODE_INT     = 5'h00;
    localparam logic [4:0]  CODE_NONE    = 5'h1F;
    localparam logic [3:0]  OFF_STATUS   = 4'h0;
    localparam logic [3:0]  OFF_REASON   = 4'h4;
    localparam logic [3:0]  OFF_RETADDR  = 4'h8;
    localparam logic [3:0]  OFF_ERRADDR  = 4'hC;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam logic [31:0] STATUS_RST   = 32'h0000_0000;
    typedef enum logic [1:0] {
        CIR_RUN = 2'b00,
        CIR_EXC = 2'b01,
        CIR_ERR = 2'b11
    } cir_lvl_t;
endpackage

// ---- rtl/cir_top.sv ----
// interrupt request logic with AXI4-Lite access to status and reason
// assumes synchronous level requests and one software master
//
// Functional notes
// - six hardware request pins, one per bit
// - timer drives one input when wide_variant is set; two software bits
// - enabled active level raises exception once, then none until a return or a status write clears the level flag
// - global enable zero blocks every exception
// - restore mode re-enables global enable
// - return clears error level flag if set (wide_variant only), else exception level flag
// - one mask bit per request, one enables
// - bits 8,9 software; pending until a reason write clears them
// - pins 0..5 map to bits 10..15
// - on-chip float unit makes pin 3 ignored unless wide_variant is set
// - timer compare drives bit 15 when wide_variant is set, pin 5 otherwise
// - interrupt exception sets interrupt type code
// - reason shows all pending requests
// - reason writes change only software bits
`timescale 1ns/10ps
`default_nettype none
module cir_top (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [5:0]  irq_line_n,
    input  wire logic        timer_compare,
    input  wire logic        wide_variant,
    input  wire logic        float_unit_onchip,
    input  wire logic        exc_return,
    input  wire logic [31:0] exc_pc,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irq_exception,
    output logic [31:0]      return_pc
);
    import cir_pkg::*;

    cir_if ci ();

    logic [31:0] status_reg;
    logic [1:0]  sw_req_reg;
    logic [5:0]  hw_req_reg;
    logic [4:0]  code_reg;
    logic [31:0] retaddr_reg;
    logic [31:0] erraddr_reg;
    logic [31:0] status_next;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;

    // request mapping; pins are active low
    logic [5:0] hw_live;
    logic [5:0] pin_gate;
    genvar gi;
    generate
        for (gi = 0; gi < HW_IRQS; gi++) begin : g_map
            if (gi == TIMER_HW_IDX) begin : g_tmr
                assign hw_live[gi] = wide_variant ? timer_compare
                                                  : !irq_line_n[gi];
            end else if (gi == FPU_HW_IDX) begin : g_fpu
                assign pin_gate[gi] = wide_variant || !float_unit_onchip;
                assign hw_live[gi]  = pin_gate[gi] && !irq_line_n[gi];
            end else begin : g_pin
                assign hw_live[gi] = !irq_line_n[gi];
            end
            if (gi != FPU_HW_IDX) begin : g_ng
                assign pin_gate[gi] = 1'b1;
            end
        end
    endgenerate

    // hardware bits unlatched, resampled every cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hw_req_reg <= 6'h00;
        end else begin
            hw_req_reg <= hw_live;
        end
    end

    assign ci.pending = {hw_req_reg, sw_req_reg};
    assign ci.mask    = status_reg[MASK_LSB +: IRQ_BITS];
    assign ci.enable  = status_reg[IE_BIT];

    cir_gate u_gate (
        .aclk    (aclk),
        .aresetn (aresetn),
        .g       (ci.gate)
    );

    // AXI write: address and data taken in either order
    wire        aw_ok   = aw_hold_reg || s_axi_awvalid;
    wire        w_ok    = w_hold_reg || s_axi_wvalid;
    wire        do_wr   = aw_ok && w_ok && !s_axi_bvalid;
    wire [3:0]  wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
    wire        wr_st   = do_wr && (wr_addr == OFF_STATUS);
    wire        wr_rs   = do_wr && (wr_addr == OFF_REASON);
    wire        wr_hit  = wr_st || wr_rs;
    // held data keeps its own lanes, not whatever the bus shows later
    wire [3:0]  wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb;
    wire        wr_b0   = wr_strb[0];
    wire        wr_b1   = wr_strb[1];
    wire [1:0]  lvl     = status_reg[ERL_BIT:EXL_BIT];
    wire        enter   = ci.take && lvl == 2'b00;

    always_comb begin
        status_next = status_reg;
        if (wr_st && wr_b0) begin
            status_next[7:0] = wr_data[7:0];
        end
        if (wr_st && wr_b1) begin
            status_next[15:8] = wr_data[15:8];
        end
        if (enter) begin
            status_next[EXL_BIT] = 1'b1;
            status_next[IE_BIT]  = wide_variant ? status_reg[IE_BIT] : 1'b0;
        end
        if (exc_return) begin
            if (!wide_variant) begin
                status_next[IE_BIT]  = 1'b1;
                // level cleared too, else no later exception is taken
                status_next[EXL_BIT] = 1'b0;
            end else if (status_reg[ERL_BIT]) begin
                status_next[ERL_BIT] = 1'b0;
            end else begin
                status_next[EXL_BIT] = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // software requests stay set until software clears them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sw_req_reg <= 2'h0;
        end else if (wr_rs && wr_b1) begin
            sw_req_reg <= wr_data[SW_LSB +: SW_IRQS];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            code_reg      <= CODE_NONE;
            irq_exception <= 1'b0;
            retaddr_reg   <= 32'h0000_0000;
            erraddr_reg   <= 32'h0000_0000;
            return_pc     <= 32'h0000_0000;
        end else begin
            irq_exception <= enter;
            if (enter) begin
                code_reg    <= CODE_INT;
                retaddr_reg <= exc_pc;
            end
            if (exc_return) begin
                return_pc <= status_reg[ERL_BIT] && wide_variant
                             ? erraddr_reg : retaddr_reg;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            awaddr_reg  <= 4'h0;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= !do_wr;
                awaddr_reg  <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= !do_wr;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (do_wr) begin
                w_hold_reg <= 1'b0;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;

    // AXI read
    wire [31:0] reason_word = {16'h0000, ci.pending,
                               1'b0, code_reg, 2'b00};
    wire [31:0] rd_word =
        (s_axi_araddr == OFF_STATUS)  ? status_reg :
        (s_axi_araddr == OFF_REASON)  ? reason_word :
        (s_axi_araddr == OFF_RETADDR) ? retaddr_reg :
        (s_axi_araddr == OFF_ERRADDR) ? erraddr_reg : 32'h0000_0000;
    wire rd_hit = s_axi_araddr[1:0] == 2'b00;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    pend_follows_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ##1 ci.pending[HW_LSB-SW_LSB +: HW_IRQS] == $past(hw_live))
        else $error("hardware pending not live");
    int_code_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        irq_exception |-> code_reg == CODE_INT)
        else $error("bad type code");
    restore_ie_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exc_return && !wide_variant |=> status_reg[IE_BIT])
        else $error("enable not restored");
    erl_clear_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        exc_return && wide_variant && status_reg[ERL_BIT]
        |=> !status_reg[ERL_BIT]) else $error("error level kept");
    sw_hold_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !(wr_rs && wr_b1) |=> $stable(sw_req_reg))
        else $error("software request changed without write");
    cover property (@(posedge aclk) irq_exception);
    cover property (@(posedge aclk) exc_return && wide_variant);
    cover property (@(posedge aclk) wr_rs);
endmodule
`default_nettype wire

// ---- tb/cir_src_model.sv ----
// request sources: six active-low pins and the timer compare level
// assumes the bench sets req and tmr; pins idle high when released
`timescale 1ns/10ps
`default_nettype none
module cir_src_model (
    input  wire logic       aclk,
    input  wire logic [5:0] req,
    input  wire logic       tmr,
    output logic [5:0]      irq_line_n,
    output logic            timer_compare
);
    // released pins float to their pull-up, never to the last value
    always_ff @(posedge aclk) begin
        irq_line_n    <= ~req;
        timer_compare <= tmr;
    end
endmodule
`default_nettype wire

// ---- tb/cir_top_bench.sv ----
// self-checking bench for the interrupt request logic
// assumes cir_pkg and the source model are compiled first
`timescale 1ns/10ps
`default_nettype none
module cir_top_bench;
    import cir_pkg::*;
    logic        aclk = 0, aresetn = 0, wide = 0, fpu = 0, xret = 0;
    logic        tmr = 0, tc, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, awready, wready, bvalid;
    logic        arready, rvalid, exc;
    logic [5:0]  req = 0, line_n;
    logic [3:0]  awaddr = 0, araddr = 0;
    logic [3:0]  strb = 4'hF;
    logic [31:0] pc = 0, wdata = 0, rdata, rpc;
    logic [31:0] seed = 32'h580E3B70;
    logic [1:0]  bresp, rresp;
    logic [33:0] expq[$];
    int          fail_count = 0, check_count = 0, exc_n = 0;

    always #50 aclk = ~aclk;

    cir_src_model src (.aclk(aclk), .req(req), .tmr(tmr),
        .irq_line_n(line_n), .timer_compare(tc));

    cir_top uut (.aclk(aclk), .aresetn(aresetn), .irq_line_n(line_n),
        .timer_compare(tc), .wide_variant(wide), .float_unit_onchip(fpu),
        .exc_return(xret), .exc_pc(pc), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq_exception(exc), .return_pc(rpc));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic w(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // handshakes are judged at the negedge, where everything has settled
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] r = RESP_OKAY);
        logic ta, tw, a1, w1;
        ta = 0;
        tw = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            a1 = awready && !ta;
            w1 = wready && !tw;
            @(posedge aclk);
            if (a1) begin awvalid <= 0; ta = 1; end
            if (w1) begin wvalid <= 0; tw = 1; end
        end
        do @(negedge aclk); while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, r});
        @(posedge aclk);
        bready <= 0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        expq.push_back({RESP_OKAY, e});
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        @(posedge aclk);
        rready <= 0;
    endtask

    task automatic ret();
        @(posedge aclk);
        xret <= 1;
        @(posedge aclk);
        xret <= 0;
        w(2);
    endtask

    always @(negedge aclk) begin
        logic [33:0] e;
        if (exc === 1'b1) exc_n++;
        if (rvalid === 1'b1 && rready === 1'b1) begin
            e = expq.pop_front();
            chk(rdata, e[31:0]);
            chk({30'h0, rresp}, {30'h0, e[33:32]});
        end
    end

    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        rd(OFF_STATUS, STATUS_RST);
        rd(OFF_REASON, {25'h0, CODE_NONE, 2'h0});
        wr(OFF_REASON, 32'hFFFFFFFF);
        rd(OFF_REASON, 32'h0000037C);
        wr(OFF_STATUS, 32'h00000001);
        w(4);
        chk(32'(exc_n), 32'h0);
        pc <= xs();
        wr(OFF_STATUS, 32'h00000101);
        w(4);
        chk(32'(exc_n), 32'h1);
        rd(OFF_REASON, 32'h00000300);
        rd(OFF_STATUS, 32'h00000102);
        wr(OFF_REASON, 32'h0);
        ret();
        chk(rpc, pc);
        rd(OFF_STATUS, 32'h00000101);
        // all masks open but global enable off
        wr(OFF_STATUS, 32'h0000FF00);
        for (int i = 0; i < HW_IRQS; i++) begin
            req <= 6'(1 << i);
            w(3);
            rd(OFF_REASON, 32'h1 << (HW_LSB + i));
        end
        chk(32'(exc_n), 32'h1);
        req <= 6'h0;
        w(3);
        rd(OFF_REASON, 32'h0);
        fpu <= 1;
        req <= 6'h08;
        w(3);
        rd(OFF_REASON, 32'h0);
        fpu <= 0;
        wide <= 1;
        req <= 6'h20;
        w(3);
        rd(OFF_REASON, 32'h0);
        req <= 6'h0;
        tmr <= 1;
        w(3);
        rd(OFF_REASON, 32'h00008000);
        pc <= xs();
        wr(OFF_STATUS, 32'h00008001);
        w(4);
        chk(32'(exc_n), 32'h2);
        rd(OFF_STATUS, 32'h00008003);
        wr(OFF_STATUS, 32'h00008002);
        tmr <= 0;
        ret();
        chk(rpc, pc);
        rd(OFF_STATUS, 32'h00008000);
        wr(4'h2, 32'h00000001, RESP_SLVERR);
        rd(OFF_STATUS, 32'h00008000);
        // lane 1 off: mask byte must survive the write
        strb <= 4'h1;
        wr(OFF_STATUS, 32'h0000FF07);
        strb <= 4'hF;
        rd(OFF_STATUS, 32'h00008007);
        ret();
        chk(rpc, 32'h0);
        rd(OFF_STATUS, 32'h00008003);
        req <= 6'h05;
        w(3);
        wr(OFF_STATUS, 32'h00001401);
        w(4);
        chk(32'(exc_n), 32'h3);
        rd(OFF_REASON, 32'h00001400);
        // pins 0 and 2 stay asserted: mask both under cover, open the timer
        wr(OFF_STATUS, 32'h00008003);
        wr(OFF_STATUS, 32'h00008001);
        w(6);
        chk(32'(exc_n), 32'h3);
        pc <= xs();
        tmr <= 1;
        w(6);
        chk(32'(exc_n), 32'h4);
        tmr <= 0;
        wr(OFF_STATUS, 32'h00008002);
        ret();
        chk(rpc, pc);
        rd(OFF_STATUS, 32'h00008000);
        req <= 6'h00;
        w(4);
        finish_test();
    end
endmodule
`default_nettype wire
